// ### dv/can_controller_host_pins_test.sv
// Purpose: Self-checking bench for the CAN pin-level core.
// Assumes: Inputs move at falling edges; engine model answers starts.
// Notes:   Transmit frames differ per buffer so the chosen buffer is visible.
`default_nettype none
module can_controller_host_pins_test;
    timeunit 1ns;
    timeprecision 1ps;
    import chp_pkg::*;
    logic clk, srst, one_shot, lose, rxv, crc_ok, done, lost, bus_rx, roll, err, int_n, start;
    logic idle, tx_out, rx_bit, ck_out, ck_en, ck_sof, ovf;
    logic [DIV_W-1:0] ck_div;
    logic [NUM_TX-1:0][PRIO_W-1:0] prio;
    logic [NUM_RXB-1:0][FIDX_W-1:0] fidx;
    logic [NUM_TX-1:0]  req, pin_n, pend, abrt, rts_mode, abt, rts_lvl;
    logic [NUM_RXB-1:0] rfull, rpin_n, rel, rx_mode, gp_lvl;
    logic [INT_W-1:0]   int_en, int_clr, flags;
    chp_frame_t efr, rfr;
    chp_frame_t [NUM_TX-1:0] txf;
    chp_frame_t [NUM_RXB-1:0] rbuf;
    chp_filter_t [NUM_FILT-1:0] filt;
    logic [NUM_RXB-1:0][ID_W-1:0] mask;
    int failures, samples_checked, starts, n, s0;
    chp_top u_dut (.i_ref_clk(clk), .i_srst(srst), .i_tx_request_pin_n(pin_n),
        .i_bus_rx_in(bus_rx), .o_bus_tx_out(tx_out), .o_prescaled_clock_out(ck_out),
        .o_rx_full_pin_n(rpin_n), .o_int_n(int_n), .i_rts_mode_req(rts_mode),
        .o_rts_level(rts_lvl), .i_rxpin_int_mode(rx_mode),
        .i_rxpin_gp_level(gp_lvl), .i_int_enable(int_en), .i_int_clear(int_clr),
        .o_int_flags(flags), .i_one_shot(one_shot), .i_tx_req(req), .i_tx_abort(abt),
        .i_tx_prio(prio), .i_tx_frame(txf), .o_tx_pending(pend), .o_tx_aborted(abrt),
        .i_filter(filt), .i_mask(mask), .i_rollover(roll), .i_rx_release(rel), .o_rx_buf(rbuf),
        .o_rx_full(rfull), .o_rx_filt_idx(fidx), .o_rx_overflow(ovf), .i_prescaled_clock_out_en(ck_en),
        .i_prescaled_clock_out_sof(ck_sof), .i_prescaled_clock_out_div(ck_div), .o_eng_start(start), .o_eng_frame(efr),
        .i_eng_done(done), .i_eng_lost(lost), .i_eng_error(err), .i_eng_tx_bit(bus_rx),
        .i_eng_bus_idle(idle), .o_eng_rx_bit(rx_bit), .i_eng_rx_valid(rxv),
        .i_eng_rx_crc_ok(crc_ok), .i_eng_rx_frame(rfr));
    chp_eng_model u_eng (.i_ref_clk(clk), .i_start(start), .i_lose(lose), .o_done(done),
        .o_lost(lost));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk) if (start === 1'b1) starts++;
    // ------------------------------------------------------------
    // Checks and scenarios
    // ------------------------------------------------------------
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic t_tx;
        req = 3'h1;
        @(negedge clk);
        req = 3'h0;
        chk(pend, 3'h1);
        for (n = 0; n < 9 && start !== 1'b1; n++) @(negedge clk);
        chk(efr, txf[0]);
        for (n = 0; n < 20 && pend[0] !== 1'b0; n++) @(negedge clk);
        chk({flags[INT_TX0], int_n}, 2'h2);
        int_clr = 6'h3F;
        @(negedge clk);
        int_clr = 6'h00;
        chk(int_n, 1'b1);
    endtask : t_tx
    task automatic t_one;
        one_shot = 1'b1;
        lose = 1'b1;
        s0 = starts;
        req = 3'h2;
        @(negedge clk);
        req = 3'h0;
        for (n = 0; n < 20 && pend[1] !== 1'b0; n++) @(negedge clk);
        repeat (4) @(negedge clk);
        chk({abrt[1], pend[1]}, 2'h2);
        chk(starts - s0, 1);
        one_shot = 1'b0;
        lose = 1'b0;
    endtask : t_one
    task automatic t_pin;
        rts_mode = 3'h4;
        pin_n = 3'h1;
        for (n = 0; n < 12 && pend[2] !== 1'b1; n++) @(negedge clk);
        chk(pend[2], 1'b1);
        chk({rts_lvl, pend[1]}, 4'h2);
        pin_n = 3'h7;
        for (n = 0; n < 20 && pend[2] !== 1'b0; n++) @(negedge clk);
        chk({flags[INT_TX0 + 2], pend[2]}, 2'h2);
    endtask : t_pin
    task automatic t_prio;
        prio = 6'h01;
        req = 3'h3;
        @(negedge clk);
        req = 3'h0;
        @(negedge clk);
        abt = 3'h2;
        chk(efr, txf[0]);
        @(negedge clk);
        abt = 3'h0;
        chk({abrt, pend}, 6'h11);
        for (n = 0; n < 20 && pend !== 3'h0; n++) @(negedge clk);
        chk(pend, 3'h0);
    endtask : t_prio
    task automatic t_rx;
        rxv = 1'b1;
        @(negedge clk);
        chk(rfull, 2'h0);
        crc_ok = 1'b1;
        @(negedge clk);
        roll = 1'b1;
        chk({rfull, rpin_n, flags[INT_RX0]}, 5'hD);
        chk(rbuf[0], rfr);
        @(negedge clk);
        chk({rfull, ovf}, 3'h6);
        @(negedge clk);
        {rxv, rel} = 3'h3;
        chk({ovf, fidx[0], fidx[1]}, 7'h49);
        @(negedge clk);
        rel = 2'h0;
        chk({rfull, ovf, rpin_n}, 5'h03);
        {rx_mode, gp_lvl} = 4'h1;
        @(negedge clk);
        chk(rpin_n, 2'h1);
    endtask : t_rx
    task automatic t_sof;
        logic [3:0] s;
        {ck_en, ck_sof} = 2'h3;
        bus_rx = 1'b0;
        for (n = 0; n < 12 && ck_out !== 1'b1; n++) @(negedge clk);
        chk({ck_out, rx_bit, tx_out}, 3'h4);
        err = 1'b1;
        @(negedge clk);
        {err, bus_rx} = 2'h1;
        chk({ck_out, flags[INT_ERR]}, 2'h1);
        {ck_sof, ck_div} = 3'h1;
        @(negedge clk);
        for (n = 0; n < 4; n++) begin
            s[n] = ck_out;
            @(negedge clk);
        end
        chk({s[0] ^ s[2], s[1] ^ s[3]}, 2'h3);
    endtask : t_sof
    initial begin
        {srst, one_shot, lose, rxv, crc_ok, roll, err, bus_rx, idle} = 9'h103;
        {req, rel, int_clr, rts_mode, abt, prio, ck_en, ck_sof, ck_div} = '0;
        {pin_n, rx_mode, gp_lvl, int_en} = {3'h7, 2'h3, 2'h3, 6'h3F};
        {failures, samples_checked, starts} = '0;
        txf = {3{1'b0, 1'b0, 29'h123, 4'h8, 64'h0123_4567_89AB_CDEF}};
        txf[1].dlc = 4'h0;
        txf[2].dlc = 4'h1;
        rfr = {1'b0, 1'b0, 29'h123, 4'h2, 64'hBEEF_0000_0000_0000};
        filt = {6{ID_W'(0), 1'b1}};
        filt[1] = {11'h123, 16'hBEEF, 2'h0, 1'b0};
        mask = {2{29'h1FFF_FFFF}};
        repeat (10) @(negedge clk);
        srst = 1'b0;
        t_tx();
        t_one();
        t_pin();
        t_prio();
        t_rx();
        t_sof();
        report_and_stop();
    end
    initial begin
        #20000;
        failures++;
        report_and_stop();
    end
endmodule : can_controller_host_pins_test
`default_nettype wire

// ### dv/chp_eng_model.sv
// Purpose: Behavioural protocol engine facing the core.
// Assumes: Results only after a start, driven at falling edges.
// Notes:   i_lose turns a success into lost arbitration.
`default_nettype none
module chp_eng_model (
    input  wire logic i_ref_clk,
    input  wire logic i_start,
    input  wire logic i_lose,
    output logic      o_done,
    output logic      o_lost
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_done = 1'b0;
        o_lost = 1'b0;
        forever begin
            @(posedge i_ref_clk iff i_start === 1'b1);
            repeat (3) @(negedge i_ref_clk);
            o_done = !i_lose;
            o_lost = i_lose;
            @(negedge i_ref_clk);
            o_done = 1'b0;
            o_lost = 1'b0;
        end
    end
endmodule : chp_eng_model
`default_nettype wire

// ### pkg/chp_pkg.sv
// Purpose: Shared constants and types for the CAN controller pin-level core.
// Assumes: One 200 MHz clock; protocol bit engine sits outside this core.
// Notes:   Frame data byte 0 occupies the top byte of the data field.
`default_nettype none

package chp_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_TX       = 3;
    localparam int NUM_RXB      = 2;
    localparam int NUM_FILT     = 6;
    localparam int FILT_RX_BUFFER_0    = 2;   // Filters below this index feed buffer 0
    localparam int ID_W         = 29;
    localparam int STD_ID_W     = 11;
    localparam int DATA_W       = 64;
    localparam int DBYTE_FILT_W = 16;  // First two data bytes
    localparam int DLC_W        = 4;
    localparam int FIDX_W       = 3;
    localparam int TX_IDX_W     = 2;
    localparam int PRIO_W       = 2;
    localparam int DIV_W        = 2;
    localparam int CNT_W        = 3;
    localparam int NUM_PINS     = NUM_TX + 1;
    localparam int RX_PIN       = NUM_TX;  // Bus receive pin sits above the request pins

    // ----------------------------------------------------------------
    // Interrupt flag positions
    // ----------------------------------------------------------------
    localparam int INT_W   = 6;
    localparam int INT_RX0 = 0;
    localparam int INT_TX0 = 2;
    localparam int INT_ERR = 5;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic                RECESSIVE  = 1'b1;
    localparam logic [NUM_PINS-1:0] PINS_IDLE  = 4'hF;  // Pull-ups and idle bus
    localparam logic [NUM_RXB-1:0]  RXPIN_IDLE = 2'h3;

    typedef struct packed {
        logic              ide;
        logic              rtr;
        logic [ID_W-1:0]   id;
        logic [DLC_W-1:0]  dlc;
        logic [DATA_W-1:0] data;
    } chp_frame_t;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic            ext;
    } chp_filter_t;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_BUSY = 1'b1
    } chp_tx_state_t;

endpackage : chp_pkg

`default_nettype wire

// ### rtl/chp_accept_filter.sv
// Purpose: Acceptance match of one received frame against filters and masks.
// Assumes: Purely combinational; caller registers the result.
// Notes:   Lowest-numbered matching filter wins within each buffer group.
`default_nettype none

module chp_accept_filter (
    input  wire chp_pkg::chp_frame_t                                  i_frame,
    input  wire chp_pkg::chp_filter_t [chp_pkg::NUM_FILT-1:0]         i_filter,
    input  wire logic [chp_pkg::NUM_RXB-1:0][chp_pkg::ID_W-1:0]       i_mask,
    output logic      [chp_pkg::NUM_RXB-1:0]                          o_hit,
    output logic      [chp_pkg::NUM_RXB-1:0][chp_pkg::FIDX_W-1:0]     o_idx
);
    import chp_pkg::*;

    logic [ID_W-1:0] key;

    // ----------------------------------------------------------------
    // Compare key
    // ----------------------------------------------------------------
    function automatic logic [ID_W-1:0] make_key(input chp_frame_t f);
        if (f.ide) begin
            make_key = f.id;
        end else if (f.rtr) begin
            make_key = {f.id[STD_ID_W-1:0], {(ID_W-STD_ID_W){1'b0}}};
        end else begin
            // Standard data frames also expose their first two data bytes
            make_key = {f.id[STD_ID_W-1:0], f.data[DATA_W-1 -: DBYTE_FILT_W],
                        {(ID_W-STD_ID_W-DBYTE_FILT_W){1'b0}}};
        end
    endfunction : make_key

    always_comb begin
        key   = make_key(i_frame);
        o_hit = '0;
        o_idx = '0;
        // Descending scan so the lowest index is written last
        for (int f = NUM_FILT - 1; f >= 0; f--) begin
            if (i_filter[f].ext == i_frame.ide &&
                ((key ^ i_filter[f].id) & i_mask[(f < FILT_RX_BUFFER_0) ? 0 : 1]) == '0) begin
                o_hit[(f < FILT_RX_BUFFER_0) ? 0 : 1] = 1'b1;
                o_idx[(f < FILT_RX_BUFFER_0) ? 0 : 1] = FIDX_W'(f);
            end
        end
    end

endmodule : chp_accept_filter

`default_nettype wire

// ### rtl/chp_top.sv
// Purpose: Pin-level core of a stand-alone CAN controller: transmit
//          scheduling, acceptance into two receive buffers, pins, interrupt.
// Assumes: Bit-level protocol engine and host serial link sit outside;
//          host settings arrive as ports synchronous to i_ref_clk.
// Notes:   Request pins and bus receive pin are asynchronous and synchronised.
`default_nettype none

module chp_top #(
    parameter int PRIO_W = chp_pkg::PRIO_W
) (
    input  wire logic                                        i_ref_clk,
    input  wire logic                                        i_srst,
    input  wire logic [chp_pkg::NUM_TX-1:0]                  i_tx_request_pin_n,
    input  wire logic                                        i_bus_rx_in,
    output logic                                             o_bus_tx_out,
    output logic                                             o_prescaled_clock_out,
    output logic [chp_pkg::NUM_RXB-1:0]                      o_rx_full_pin_n,
    output logic                                             o_int_n,
    input  wire logic [chp_pkg::NUM_TX-1:0]                  i_rts_mode_req,
    output logic [chp_pkg::NUM_TX-1:0]                       o_rts_level,
    input  wire logic [chp_pkg::NUM_RXB-1:0]                 i_rxpin_int_mode,
    input  wire logic [chp_pkg::NUM_RXB-1:0]                 i_rxpin_gp_level,
    input  wire logic [chp_pkg::INT_W-1:0]                   i_int_enable,
    input  wire logic [chp_pkg::INT_W-1:0]                   i_int_clear,
    output logic [chp_pkg::INT_W-1:0]                        o_int_flags,
    input  wire logic                                        i_one_shot,
    input  wire logic [chp_pkg::NUM_TX-1:0]                  i_tx_req,
    input  wire logic [chp_pkg::NUM_TX-1:0]                  i_tx_abort,
    input  wire logic [chp_pkg::NUM_TX-1:0][PRIO_W-1:0]      i_tx_prio,
    input  wire chp_pkg::chp_frame_t [chp_pkg::NUM_TX-1:0]   i_tx_frame,
    output logic [chp_pkg::NUM_TX-1:0]                       o_tx_pending,
    output logic [chp_pkg::NUM_TX-1:0]                       o_tx_aborted,
    input  wire chp_pkg::chp_filter_t [chp_pkg::NUM_FILT-1:0] i_filter,
    input  wire logic [chp_pkg::NUM_RXB-1:0][chp_pkg::ID_W-1:0] i_mask,
    input  wire logic                                        i_rollover,
    input  wire logic [chp_pkg::NUM_RXB-1:0]                 i_rx_release,
    output chp_pkg::chp_frame_t [chp_pkg::NUM_RXB-1:0]       o_rx_buf,
    output logic [chp_pkg::NUM_RXB-1:0]                      o_rx_full,
    output logic [chp_pkg::NUM_RXB-1:0][chp_pkg::FIDX_W-1:0] o_rx_filt_idx,
    output logic                                             o_rx_overflow,
    input  wire logic                                        i_prescaled_clock_out_en,
    input  wire logic                                        i_prescaled_clock_out_sof,
    input  wire logic [chp_pkg::DIV_W-1:0]                   i_prescaled_clock_out_div,
    output logic                                             o_eng_start,
    output chp_pkg::chp_frame_t                              o_eng_frame,
    input  wire logic                                        i_eng_done,
    input  wire logic                                        i_eng_lost,
    input  wire logic                                        i_eng_error,
    input  wire logic                                        i_eng_tx_bit,
    input  wire logic                                        i_eng_bus_idle,
    output logic                                             o_eng_rx_bit,
    input  wire logic                                        i_eng_rx_valid,
    input  wire logic                                        i_eng_rx_crc_ok,
    input  wire chp_pkg::chp_frame_t                         i_eng_rx_frame
);
    import chp_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [NUM_PINS-1:0] sync1, sync2, sync3, pin_level, pin_prev, next_pin_level;
    logic [NUM_TX-1:0]   rts_fall;
    logic                sof_evt;

    always_comb begin
        next_pin_level = pin_level;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_pin_level[i] = sync3[i];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sync1     <= PINS_IDLE;
            sync2     <= PINS_IDLE;
            sync3     <= PINS_IDLE;
            pin_level <= PINS_IDLE;
            pin_prev  <= PINS_IDLE;
        end else begin
            sync1     <= {i_bus_rx_in, i_tx_request_pin_n};
            sync2     <= sync1;
            sync3     <= sync2;
            pin_level <= next_pin_level;
            pin_prev  <= pin_level;
        end
    end

    // Pins idle high, so a request is the falling edge
    assign rts_fall     = pin_prev[NUM_TX-1:0] & ~pin_level[NUM_TX-1:0];
    assign sof_evt      = pin_prev[RX_PIN] & ~pin_level[RX_PIN] & i_eng_bus_idle;
    assign o_rts_level  = pin_level[NUM_TX-1:0];
    assign o_eng_rx_bit = pin_level[RX_PIN];

    // ----------------------------------------------------------------
    // Transmit scheduler
    // ----------------------------------------------------------------
    chp_tx_state_t         state, next_state;
    logic [TX_IDX_W-1:0]   cur, next_cur;
    logic                  abort_cur, next_abort_cur;
    logic [NUM_TX-1:0]     next_pending, next_aborted, req_set, clr, abort_evt, tx_done_evt;
    logic                  next_eng_start;
    chp_frame_t            next_eng_frame;

    // Highest priority wins; ties go to the higher buffer index
    function automatic logic [TX_IDX_W-1:0] pick_tx(
        input logic [NUM_TX-1:0]             pend,
        input logic [NUM_TX-1:0][PRIO_W-1:0] prio
    );
        logic found;
        found   = 1'b0;
        pick_tx = '0;
        for (int i = 0; i < NUM_TX; i++) begin
            if (pend[i] && (!found || prio[i] >= prio[pick_tx])) begin
                pick_tx = TX_IDX_W'(i);
                found   = 1'b1;
            end
        end
    endfunction : pick_tx

    always_comb begin
        next_state     = state;
        next_cur       = cur;
        next_abort_cur = abort_cur;
        next_eng_start = 1'b0;
        next_eng_frame = o_eng_frame;
        clr            = '0;
        abort_evt      = '0;
        tx_done_evt    = '0;
        // Host strobes are already on this clock; the serial link lives outside
        req_set = i_tx_req | (rts_fall & i_rts_mode_req);
        unique case (state)
            TX_IDLE: begin
                abort_evt = i_tx_abort & o_tx_pending;
                if (|(o_tx_pending & ~i_tx_abort)) begin
                    next_cur       = pick_tx(o_tx_pending & ~i_tx_abort, i_tx_prio);
                    next_eng_start = 1'b1;
                    next_eng_frame = i_tx_frame[next_cur];
                    next_abort_cur = 1'b0;
                    next_state     = TX_BUSY;
                end
            end
            TX_BUSY: begin
                // A frame on the wire cannot be cut; abort only blocks a retry
                for (int i = 0; i < NUM_TX; i++) begin
                    if (i_tx_abort[i] && o_tx_pending[i] && TX_IDX_W'(i) != cur) begin
                        abort_evt[i] = 1'b1;
                    end
                end
                if (i_tx_abort[cur]) begin
                    next_abort_cur = 1'b1;
                end
                if (i_eng_done) begin
                    clr[cur]         = 1'b1;
                    tx_done_evt[cur] = 1'b1;
                    next_state       = TX_IDLE;
                end else if (i_eng_lost || i_eng_error) begin
                    if (i_one_shot || abort_cur || i_tx_abort[cur]) begin
                        abort_evt[cur] = 1'b1;
                    end
                    next_state = TX_IDLE;
                end
            end
        endcase
        // A new request in the same cycle wins over any clear
        next_pending = (o_tx_pending & ~clr & ~abort_evt) | req_set;
        next_aborted = (o_tx_aborted & ~req_set) | abort_evt;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state        <= TX_IDLE;
            cur          <= '0;
            abort_cur    <= 1'b0;
            o_tx_pending <= '0;
            o_tx_aborted <= '0;
            o_eng_start  <= 1'b0;
            o_eng_frame  <= '0;
            o_bus_tx_out <= RECESSIVE;
        end else begin
            state        <= next_state;
            cur          <= next_cur;
            abort_cur    <= next_abort_cur;
            o_tx_pending <= next_pending;
            o_tx_aborted <= next_aborted;
            o_eng_start  <= next_eng_start;
            o_eng_frame  <= next_eng_frame;
            o_bus_tx_out <= i_eng_tx_bit;
        end
    end

    // ----------------------------------------------------------------
    // Receive acceptance and buffers
    // ----------------------------------------------------------------
    logic [NUM_RXB-1:0]              hit, store, next_full, next_pin_n;
    logic [NUM_RXB-1:0][FIDX_W-1:0]  hit_idx;
    logic                            accept, next_overflow;

    chp_accept_filter u_filter (
        .i_frame  (i_eng_rx_frame),
        .i_filter (i_filter),
        .i_mask   (i_mask),
        .o_hit    (hit),
        .o_idx    (hit_idx)
    );

    always_comb begin
        accept        = i_eng_rx_valid & i_eng_rx_crc_ok;
        store         = '0;
        // Release clears overflow, but a fresh overflow in that cycle still wins
        next_overflow = o_rx_overflow & ~(|i_rx_release);
        if (accept && hit[0]) begin
            if (!o_rx_full[0]) begin
                store[0] = 1'b1;
            end else if (i_rollover && !o_rx_full[1]) begin
                store[1] = 1'b1;
            end else begin
                next_overflow = 1'b1;
            end
        end else if (accept && hit[1]) begin
            if (!o_rx_full[1]) begin
                store[1] = 1'b1;
            end else begin
                next_overflow = 1'b1;
            end
        end
        // Store only happens into an empty buffer, so release never races it
        next_full = (o_rx_full & ~i_rx_release) | store;
        for (int b = 0; b < NUM_RXB; b++) begin
            next_pin_n[b] = i_rxpin_int_mode[b] ? ~next_full[b] : i_rxpin_gp_level[b];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_rx_buf        <= '0;
            o_rx_full       <= '0;
            o_rx_filt_idx   <= '0;
            o_rx_overflow   <= 1'b0;
            o_rx_full_pin_n <= RXPIN_IDLE;
        end else begin
            for (int b = 0; b < NUM_RXB; b++) begin
                if (store[b]) begin
                    o_rx_buf[b]      <= i_eng_rx_frame;
                    o_rx_filt_idx[b] <= hit[0] ? hit_idx[0] : hit_idx[1];
                end
            end
            o_rx_full       <= next_full;
            o_rx_overflow   <= next_overflow;
            o_rx_full_pin_n <= next_pin_n;
        end
    end

    // ----------------------------------------------------------------
    // General interrupt
    // ----------------------------------------------------------------
    logic [INT_W-1:0] int_evt, next_flags;

    always_comb begin
        int_evt                           = '0;
        int_evt[INT_RX0 +: NUM_RXB]       = store;
        int_evt[INT_TX0 +: NUM_TX]        = tx_done_evt;
        int_evt[INT_ERR]                  = i_eng_error;
        next_flags = (o_int_flags & ~i_int_clear) | int_evt;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_int_flags <= '0;
            o_int_n     <= 1'b1;
        end else begin
            o_int_flags <= next_flags;
            o_int_n     <= ~|(next_flags & i_int_enable);
        end
    end

    // ----------------------------------------------------------------
    // Clock-out pin
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] div_cnt, next_div_cnt;
    logic             div_clk, next_div_clk, sof_q, next_sof_q, next_prescaled_clock_out;

    // Output toggles every 2^sel cycles, so the pin runs at ref / 2^(sel+1)
    function automatic logic [CNT_W-1:0] half_count(input logic [DIV_W-1:0] sel);
        half_count = CNT_W'((1 << sel) - 1);
    endfunction : half_count

    always_comb begin
        next_div_cnt = div_cnt + CNT_W'(1);
        next_div_clk = div_clk;
        if (div_cnt >= half_count(i_prescaled_clock_out_div)) begin
            next_div_cnt = '0;
            next_div_clk = ~div_clk;
        end
        next_sof_q  = sof_evt | (sof_q & ~(i_eng_rx_valid | i_eng_error));
        next_prescaled_clock_out = i_prescaled_clock_out_en & (i_prescaled_clock_out_sof ? next_sof_q : next_div_clk);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            div_cnt               <= '0;
            div_clk               <= 1'b0;
            sof_q                 <= 1'b0;
            o_prescaled_clock_out <= 1'b0;
        end else begin
            div_cnt               <= next_div_cnt;
            div_clk               <= next_div_clk;
            sof_q                 <= next_sof_q;
            o_prescaled_clock_out <= next_prescaled_clock_out;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    start_pulse_a: assert property (o_eng_start |=> !o_eng_start ##1 state == TX_BUSY || !o_eng_start)
        else $error("transmit start longer than one cycle");
    start_owner_a: assert property (o_eng_start |-> state == TX_BUSY && o_tx_pending[cur])
        else $error("transmit started without a pending buffer");
    rts_request_a: assert property (rts_fall[0] && i_rts_mode_req[0] |=> o_tx_pending[0])
        else $error("request pin edge did not mark buffer pending");
    rts_plain_a: assert property (rts_fall[1] && !i_rts_mode_req[1] && !i_tx_req[1]
                                   && !o_tx_pending[1] |=> !o_tx_pending[1])
        else $error("plain input pin raised a request");
    one_shot_a: assert property (state == TX_BUSY && i_one_shot && !i_eng_done
                                  && (i_eng_lost || i_eng_error) && !req_set[cur]
                                  |=> !o_tx_pending[$past(cur)] && o_tx_aborted[$past(cur)])
        else $error("one-shot transmission was kept for retry");
    int_pin_a: assert property (##1 o_int_n == !(|(o_int_flags & $past(i_int_enable))))
        else $error("interrupt pin disagrees with enabled flags");
    rx_flag_a: assert property (store[0] |=> o_int_flags[INT_RX0] && o_rx_full[0])
        else $error("stored frame did not raise its flag");
    rx_crc_a: assert property (i_eng_rx_valid && !i_eng_rx_crc_ok |-> store == '0)
        else $error("errored frame entered a receive buffer");
    rx_pin_a: assert property (##1 $past(i_rxpin_int_mode[0])
                               |-> o_rx_full_pin_n[0] == !o_rx_full[0])
        else $error("receive pin does not follow buffer state");
    rollover_a: assert property (accept && hit[0] && o_rx_full[0] && i_rollover
                                 && !o_rx_full[1] |=> o_rx_full[1])
        else $error("rollover did not place frame in second buffer");
    sof_out_a: assert property (sof_evt && i_prescaled_clock_out_en && i_prescaled_clock_out_sof
                                |=> o_prescaled_clock_out)
        else $error("start of frame not shown on clock pin");
    reset_a: assert property (disable iff (1'b0) i_srst
                              |=> o_int_n && o_bus_tx_out && o_tx_pending == '0)
        else $error("outputs not at rest after reset");

    one_shot_c: cover property (state == TX_BUSY && i_one_shot && i_eng_lost);
    rollover_c: cover property (store[1] && hit[0]);
    rts_start_c: cover property (rts_fall[2] && i_rts_mode_req[2] ##[1:4] o_eng_start);

endmodule : chp_top

`default_nettype wire
